// *** irq_dma_sink.sv ***
// Model of the DMA controller fed by the timer request logic
`timescale 1ns/10ps
`default_nettype none
module irq_dma_sink
  import tim_irq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clear,
  input wire dma_requests_t i_dma_req,
  output dma_requests_t o_dma_seen
);
  // Sticky, so a one-cycle request is not lost between bus cycles
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || i_clear) begin
      o_dma_seen <= '0;
    end else begin
      o_dma_seen <= o_dma_seen | i_dma_req;
    end
  end
endmodule
`default_nettype wire

// *** tim_irq_dma_ctrl.sv ***
// Interrupt and DMA request enable and status logic with an AXI4-Lite slave
//
// Overview of operation
// R1: Trigger DMA request gated by bit 14
// R2: Swap event DMA request gated by bit 13
// R3: Channel DMA requests gated by bits 9-12
// R4: Update DMA request gated by bit 8
// R5: Brake interrupt gated by bit 7
// R6: Trigger interrupt gated by bit 6
// R7: Swap event interrupt gated by bit 5
// R8: Channel interrupts gated by bits 1-4
// R9: Update interrupt gated by bit 0; enables reset zero
// R10: Over-capture flags only meaningful in capture mode
// R11: Capture while event flag set sets over-capture
// R12: Writing zero clears over-capture until next
// R13: Brake active level sets sticky brake flag; code sets it only on entry to the active level
// R14: Trigger event sets trigger flag; gated any edge
// R15: Swap event sets swap flag
// R16: Reserved bits read zero, ignore writes
// R17: Capture sets flag; cleared by write or read
// R18: Update event sets update flag
// R19: Gated mode counts only while trigger high
// R20: Writing one leaves status flags unchanged
// R21: Interrupt high while any flag and enable set
`timescale 1ns/10ps
`default_nettype none
module tim_irq_dma_ctrl
  import tim_irq_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire timer_events_t i_events,
  input wire logic [CHANNELS-1:0] i_chan_is_input,
  input wire logic i_brake_pin,
  input wire logic i_brake_active_high,
  input wire logic i_trigger_input,
  output logic o_count_enable,
  output logic o_irq,
  output dma_requests_t o_dma_req
);

  logic [15:0] enable_reg;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic [2:0] slave_mode_reg;
  logic [1:0] brake_sync_reg;
  logic [1:0] trig_sync_reg;
  logic brake_level_prev_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic do_write;
  logic [15:0] wr_mask;
  logic wr_enable;
  logic wr_status;
  logic rd_take;
  logic [CHANNELS-1:0] capture_reg_read;
  logic brake_active;
  logic brake_detect;
  logic [15:0] irq_sources;
  logic [CHANNELS-1:0] chan_dma_next;

  // Pins pass two flops before any logic looks at them
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      brake_sync_reg <= 2'b00;
      trig_sync_reg <= 2'b00;
    end else begin
      brake_sync_reg <= {brake_sync_reg[0], i_brake_pin};
      trig_sync_reg <= {trig_sync_reg[0], i_trigger_input};
    end
  end

  assign brake_active = (brake_sync_reg[1] == i_brake_active_high);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      // Taken as active at reset: an idle level must be seen before a brake counts
      brake_level_prev_reg <= 1'b1;
    end else begin
      brake_level_prev_reg <= brake_active;
    end
  end

  // Edge detect on entry to the active level, re-arming only after the level goes away
  assign brake_detect = brake_active && !brake_level_prev_reg;
  assign o_count_enable = (slave_mode_reg == SLAVE_MODE_GATED) ? trig_sync_reg[1] : 1'b1; // see R19

  // Write channel: address and data may arrive in either order
  assign o_awready = !aw_held_reg && !o_bvalid;
  assign o_wready = !w_held_reg && !o_bvalid;
  assign do_write = aw_held_reg && w_held_reg && !o_bvalid;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end else if (i_awvalid && o_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= i_awaddr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= i_wdata;
      wstrb_reg <= i_wstrb;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp <= (wr_enable || wr_status || awaddr_reg == SLAVE_MODE_OFFSET) ?
                 RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  assign wr_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_enable = do_write && awaddr_reg == ENABLE_OFFSET;
  assign wr_status = do_write && awaddr_reg == STATUS_OFFSET;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      enable_reg <= ENABLE_RESET; // see R9
    end else if (wr_enable) begin
      enable_reg <= ((enable_reg & ~wr_mask) | (wdata_reg[15:0] & wr_mask)) & ENABLE_MASK; // see R16
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      slave_mode_reg <= SLAVE_MODE_RESET;
    end else if (do_write && awaddr_reg == SLAVE_MODE_OFFSET && wstrb_reg[0]) begin
      slave_mode_reg <= wdata_reg[2:0];
    end
  end

  // Read channel
  assign o_arready = !o_rvalid;
  assign rd_take = i_arvalid && o_arready;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      o_rvalid <= 1'b1;
      o_rresp <= RESP_OKAY;
      case (i_araddr)
        ENABLE_OFFSET: o_rdata <= {16'h0000, enable_reg};
        STATUS_OFFSET: o_rdata <= {16'h0000, status_reg & STATUS_MASK}; // see R16
        SLAVE_MODE_OFFSET: o_rdata <= {29'h000_0000, slave_mode_reg};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Capture register reads arrive as pulses from the capture datapath
  assign capture_reg_read = i_events.capture_read;

  // Status: clear by writing zero, hardware set wins over the clear
  always_comb begin
    status_next = status_reg;
    if (wr_status) begin
      status_next = status_reg & (wdata_reg[15:0] | ~wr_mask); // see R12, R20
    end
    for (int c = 0; c < CHANNELS; c++) begin
      if (capture_reg_read[c] && i_chan_is_input[c]) begin
        status_next[CHAN_BIT_LO + c] = 1'b0; // see R17
      end
    end
    if (i_events.update) begin
      status_next[UPDATE_BIT] = 1'b1; // see R18
    end
    for (int c = 0; c < CHANNELS; c++) begin
      if (i_chan_is_input[c] && i_events.capture[c]) begin
        status_next[CHAN_BIT_LO + c] = 1'b1; // see R17
        if (status_reg[CHAN_BIT_LO + c]) begin
          status_next[OVERCAP_LO + c] = 1'b1; // see R10, R11
        end
      end
      if (!i_chan_is_input[c] && i_events.compare[c]) begin
        status_next[CHAN_BIT_LO + c] = 1'b1;
      end
    end
    if (i_events.swap) begin
      status_next[SWAP_BIT] = 1'b1; // see R15
    end
    if ((slave_mode_reg == SLAVE_MODE_GATED) ? i_events.trigger_any_edge
                                             : i_events.trigger_edge) begin
      status_next[TRIGGER_BIT] = 1'b1; // see R14
    end
    if (brake_detect) begin
      status_next[BRAKE_BIT] = 1'b1; // see R13
    end
    status_next = status_next & STATUS_MASK; // see R16
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Interrupt enables sit at the same positions as their flags
  assign irq_sources = status_reg & enable_reg & 16'h00FF;
  assign o_irq = |irq_sources; // see R5, R6, R7, R8, R9, R21

  // Channel requests follow a capture or a compare pulse
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan_dma
    assign chan_dma_next[c] = (i_events.capture[c] || i_events.compare[c]) &&
                              enable_reg[CHAN_DMA_LO + c]; // see R3
  end

  // One process owns the whole request word, so no field has two drivers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_dma_req <= '0;
    end else begin
      o_dma_req.update <= i_events.update && enable_reg[UPDATE_DMA_BIT]; // see R4
      o_dma_req.chan <= chan_dma_next; // see R3
      o_dma_req.swap <= i_events.swap && enable_reg[SWAP_DMA_BIT]; // see R2
      // Only a fresh trigger flag requests, so a burst of triggers asks once
      o_dma_req.trigger <= status_next[TRIGGER_BIT] && !status_reg[TRIGGER_BIT] &&
                           enable_reg[TRIGGER_DMA_BIT]; // see R1
    end
  end

  // Rule checks; channel 0 stands for the other channels
  chk_trig_dma_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R1
    o_dma_req.trigger |-> $past(enable_reg[TRIGGER_DMA_BIT]))
    else $error("trigger dma without enable");
  chk_swap_dma_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R2
    $past(i_events.swap) && $past(enable_reg[SWAP_DMA_BIT]) && $past(i_reset_n) |-> o_dma_req.swap)
    else $error("swap dma request missing");
  chk_chan_dma_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R3
    o_dma_req.chan[0] |-> $past(enable_reg[CHAN_DMA_LO]))
    else $error("channel dma without enable");
  chk_update_dma_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R4
    o_dma_req.update == ($past(i_events.update) && $past(enable_reg[UPDATE_DMA_BIT])))
    else $error("update dma mismatch");
  chk_irq_or_terms: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R21
    i_events.update && enable_reg[UPDATE_BIT] && !wr_enable |=> o_irq)
    else $error("irq not raised by enabled flag");
  chk_overcap_set: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R11
    i_chan_is_input[0] && i_events.capture[0] && status_reg[CHAN_BIT_LO]
    |=> status_reg[OVERCAP_LO])
    else $error("over-capture not set");
  chk_brake_sticky: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R13
    status_reg[BRAKE_BIT] && !wr_status |=> status_reg[BRAKE_BIT])
    else $error("brake flag dropped without clear");
  chk_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R16
    (status_reg & ~STATUS_MASK) == 16'h0000 && !enable_reg[15])
    else $error("reserved bit set");
  chk_gated_count: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R19
    slave_mode_reg == SLAVE_MODE_GATED && !trig_sync_reg[1] |-> !o_count_enable)
    else $error("counting while gate low");
  chk_write_one_keeps: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R20
    wr_status && &wr_mask && wdata_reg[15:0] == 16'hFFFF && status_reg[UPDATE_BIT]
    |=> status_reg[UPDATE_BIT])
    else $error("write one disturbed flag");
  chk_overcap_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R12
    wr_status && wr_mask[OVERCAP_LO] && !wdata_reg[OVERCAP_LO] &&
    !(i_chan_is_input[0] && i_events.capture[0]) |=> !status_reg[OVERCAP_LO])
    else $error("over-capture not cleared");
  chk_trig_flag_set: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R14
    slave_mode_reg != SLAVE_MODE_GATED && i_events.trigger_edge |=> status_reg[TRIGGER_BIT])
    else $error("trigger flag not set");
  chk_gated_any_edge: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R14
    slave_mode_reg == SLAVE_MODE_GATED && i_events.trigger_any_edge
    |=> status_reg[TRIGGER_BIT])
    else $error("gated edge did not set trigger flag");
  chk_swap_flag_set: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R15
    i_events.swap |=> status_reg[SWAP_BIT])
    else $error("swap flag not set");
  chk_capture_flag_set: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R17
    i_chan_is_input[0] && i_events.capture[0] |=> status_reg[CHAN_BIT_LO])
    else $error("capture flag not set");
  chk_capread_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R17
    i_chan_is_input[0] && capture_reg_read[0] && !i_events.capture[0]
    |=> !status_reg[CHAN_BIT_LO])
    else $error("capture read did not clear flag");
  chk_update_flag_set: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R18
    i_events.update |=> status_reg[UPDATE_BIT])
    else $error("update flag not set");
  chk_brake_flag_set: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R13
    brake_detect |=> status_reg[BRAKE_BIT])
    else $error("brake flag not set");
  chk_irq_masked: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R5, R9
    enable_reg[7:0] == 8'h00 |-> !o_irq)
    else $error("irq raised with all enables off");
  chk_trig_dma_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R1
    enable_reg[TRIGGER_DMA_BIT] && !status_reg[TRIGGER_BIT] &&
    slave_mode_reg != SLAVE_MODE_GATED && i_events.trigger_edge |=> o_dma_req.trigger)
    else $error("trigger dma request missing");

  // Main scenarios the bench is expected to reach
  cov_overcapture: cover property (@(posedge i_clk) status_reg[OVERCAP_LO]);
  cov_irq_raised: cover property (@(posedge i_clk) $rose(o_irq));
  cov_set_beats_clear: cover property (@(posedge i_clk) wr_status && i_events.update);
  cov_trig_dma: cover property (@(posedge i_clk) o_dma_req.trigger);
  cov_gated_trigger: cover property (@(posedge i_clk)
    slave_mode_reg == SLAVE_MODE_GATED && i_events.trigger_any_edge);

endmodule
`default_nettype wire

// *** tim_irq_dma_ctrl_tb.sv ***
// Self-checking bench for the timer interrupt and DMA request logic
`timescale 1ns/10ps
`default_nettype none
`define check_eq(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tim_irq_dma_ctrl_tb
  import tim_irq_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cen, irq;
  logic [1:0] bresp, rresp;
  timer_events_t ev = '0;
  logic [3:0] is_in = 4'hF;
  logic brk = 1'b0, trg = 1'b1, clr = 1'b0, brk_hi = 1'b1;
  dma_requests_t dma, seen;
  int n_mismatch = 0;
  int check_count = 0;
  localparam logic [6:0] dma_exp [7] = '{7'h40, 7'h04, 7'h08, 7'h10, 7'h20, 7'h02, 7'h01};

  tim_irq_dma_ctrl i_tim_irq_dma_ctrl (.i_clk(clk), .i_reset_n(rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_events(ev),
    .i_chan_is_input(is_in), .i_brake_pin(brk), .i_brake_active_high(brk_hi),
    .i_trigger_input(trg), .o_count_enable(cen), .o_irq(irq), .o_dma_req(dma));
  irq_dma_sink i_irq_dma_sink (.i_clk(clk), .i_reset_n(rst_n), .i_clear(clr),
    .i_dma_req(dma), .o_dma_seen(seen));

  task automatic final_report();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic hang();
    n_mismatch++;
    $display("Error bus answer expected 1 seen 0");
    final_report();
  endtask

  // Ready sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    for (int n = 0; n < 40 && !b_hs; n++) begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // One idle edge, so a following call never re-drives bready in this step
    @(posedge clk);
    if (!b_hs) hang();
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    for (int n = 0; n < 40 && !r_hs; n++) begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk);
    if (!r_hs) hang();
  endtask

  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `check_eq("write resp", RESP_OKAY, r)
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] a, input logic [31:0] ex);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `check_eq(nm, ex, d)
    `check_eq("read resp", RESP_OKAY, r)
  endtask

  function automatic timer_events_t mk(input int i);
    timer_events_t e;
    e = '0;
    if (i == 0) e.update = 1'b1;
    else if (i < 5) e.capture[i-1] = 1'b1;
    else if (i == 5) e.swap = 1'b1;
    else e.trigger_edge = 1'b1;
    return e;
  endfunction

  task automatic pulse(input timer_events_t e);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk_reg("enable reset", ENABLE_OFFSET, 32'h0000_0000);
    chk_reg("status reset", STATUS_OFFSET, 32'h0000_0000);
    wreg(ENABLE_OFFSET, 32'h0000_FFFF);
    chk_reg("enable reserved", ENABLE_OFFSET, 32'h0000_7FFF);
    wreg(ENABLE_OFFSET, 32'h0000_0000);
    rd(32'h0000_0040, d, r);
    `check_eq("unmapped resp", RESP_SLVERR, r)
  endtask

  // Each source but brake: masked first, then enabled, cleared alone, raised again
  task automatic t_gate();
    logic [15:0] b;
    for (int i = 0; i < 7; i++) begin
      b = 16'h0001 << i;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      pulse(mk(i));
      chk_reg("status set", STATUS_OFFSET, {16'h0000, b});
      `check_eq("irq masked", 1'b0, irq)
      `check_eq("dma masked", 7'h00, seen)
      wreg(ENABLE_OFFSET, {16'h0000, b | (16'h0100 << i)});
      `check_eq("irq enabled", 1'b1, irq)
      wreg(STATUS_OFFSET, {16'h0000, ~b});
      `check_eq("irq cleared", 1'b0, irq)
      pulse(mk(i));
      `check_eq("dma enabled", dma_exp[i], seen)
      wreg(STATUS_OFFSET, 32'h0000_0000);
      wreg(ENABLE_OFFSET, 32'h0000_0000);
    end
  endtask

  task automatic t_overcap();
    timer_events_t e;
    pulse(mk(1));
    pulse(mk(1));
    chk_reg("overcapture", STATUS_OFFSET, 32'h0000_0202);
    wreg(STATUS_OFFSET, 32'h0000_FDFF);
    chk_reg("overcapture clear", STATUS_OFFSET, 32'h0000_0002);
    e = '0;
    e.capture_read[0] = 1'b1;
    pulse(e);
    chk_reg("capture read", STATUS_OFFSET, 32'h0000_0000);
    // Output mode: compare sets the flag, reads and captures leave it alone
    is_in <= 4'hE;
    e = '0;
    e.compare[0] = 1'b1;
    pulse(e);
    e.compare[0] = 1'b0;
    e.capture_read[0] = 1'b1;
    pulse(e);
    e = mk(1);
    pulse(e);
    pulse(e);
    chk_reg("output mode flag", STATUS_OFFSET, 32'h0000_0002);
    wreg(STATUS_OFFSET, 32'h0000_0000);
    is_in <= 4'hF;
  endtask

  task automatic t_brake();
    wreg(ENABLE_OFFSET, 32'h0000_0080);
    brk <= 1'b1;
    repeat (6) @(posedge clk);
    brk <= 1'b0;
    repeat (6) @(posedge clk);
    chk_reg("brake flag", STATUS_OFFSET, 32'h0000_0080);
    `check_eq("brake irq", 1'b1, irq)
    wreg(STATUS_OFFSET, 32'h0000_0000);
    `check_eq("brake irq clear", 1'b0, irq)
    // Active-low polarity: a high pin is idle, a low pin brakes
    brk <= 1'b1;
    brk_hi <= 1'b0;
    repeat (6) @(posedge clk);
    wreg(STATUS_OFFSET, 32'h0000_0000);
    chk_reg("brake idle high", STATUS_OFFSET, 32'h0000_0000);
    brk <= 1'b0;
    repeat (6) @(posedge clk);
    chk_reg("brake active low", STATUS_OFFSET, 32'h0000_0080);
    brk_hi <= 1'b1;
    repeat (6) @(posedge clk);
    wreg(STATUS_OFFSET, 32'h0000_0000);
    wreg(ENABLE_OFFSET, 32'h0000_0000);
  endtask

  task automatic t_gated();
    timer_events_t e;
    e = '0;
    e.trigger_any_edge = 1'b1;
    pulse(e);
    chk_reg("plain any edge", STATUS_OFFSET, 32'h0000_0000);
    trg <= 1'b0;
    wreg(SLAVE_MODE_OFFSET, 32'h0000_0005);
    repeat (4) @(posedge clk);
    `check_eq("gated stop", 1'b0, cen)
    trg <= 1'b1;
    repeat (4) @(posedge clk);
    `check_eq("gated run", 1'b1, cen)
    pulse(e);
    chk_reg("gated any edge", STATUS_OFFSET, 32'h0000_0040);
    chk_reg("slave mode", SLAVE_MODE_OFFSET, 32'h0000_0005);
  endtask

  initial begin
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_gate();
    t_overcap();
    t_brake();
    t_gated();
    final_report();
  end
endmodule
`default_nettype wire

// *** tim_irq_pkg.sv ***
// Package: register map, field positions and carrier types for the timer request logic
package tim_irq_pkg;

  localparam logic [31:0] ENABLE_OFFSET = 32'h0000_000C;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0010;
  localparam logic [31:0] SLAVE_MODE_OFFSET = 32'h0000_0008;

  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_MASK = 16'h7FFF;
  localparam logic [15:0] STATUS_MASK = 16'h1EFF;

  localparam int UPDATE_BIT = 0;
  localparam int CHAN_BIT_LO = 1;
  localparam int SWAP_BIT = 5;
  localparam int TRIGGER_BIT = 6;
  localparam int BRAKE_BIT = 7;
  localparam int UPDATE_DMA_BIT = 8;
  localparam int CHAN_DMA_LO = 9;
  localparam int SWAP_DMA_BIT = 13;
  localparam int TRIGGER_DMA_BIT = 14;
  localparam int OVERCAP_LO = 9;

  localparam logic [2:0] SLAVE_MODE_GATED = 3'h5;
  localparam logic [2:0] SLAVE_MODE_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timer core events, each a one-cycle pulse in the bus clock domain
  typedef struct packed {
    logic update;
    logic [3:0] capture;
    logic [3:0] compare;
    logic [3:0] capture_read;
    logic swap;
    logic trigger_edge;
    logic trigger_any_edge;
  } timer_events_t;

  typedef struct packed {
    logic update;
    logic [3:0] chan;
    logic swap;
    logic trigger;
  } dma_requests_t;

endpackage
